// ---- include/vpt_pkg.sv ----
// Shared constants for the voltage protection timing block.
// Assumes a single 10 MHz core clock and word-indexed register offsets.
package vpt_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int VPT_CLK_PERIOD_NS = 100;
  localparam int VPT_TICK_MS = 10;
  localparam int VPT_TICK_CYCLES = (VPT_TICK_MS * 1000000) / VPT_CLK_PERIOD_NS;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int VPT_DW = 16;
  localparam int VPT_AW = 6;
  localparam int VPT_ACCW = 32;
  localparam int VPT_NOV_N = 3;
  localparam int VPT_EV_N = 5;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [5:0] VPT_A_CTRL = 6'h00;
  localparam logic [5:0] VPT_A_PUV_PICKUP = 6'h01;
  localparam logic [5:0] VPT_A_PUV_MIN = 6'h02;
  localparam logic [5:0] VPT_A_PUV_DELAY = 6'h03;
  localparam logic [5:0] VPT_A_AUX_PICKUP = 6'h04;
  localparam logic [5:0] VPT_A_AUX_MIN = 6'h05;
  localparam logic [5:0] VPT_A_AUX_DELAY = 6'h06;
  localparam logic [5:0] VPT_A_NOV_BASE = 6'h10;
  localparam logic [5:0] VPT_A_CURVE_BASE = 6'h20;
  localparam logic [5:0] VPT_A_STATUS = 6'h30;
  localparam logic [5:0] VPT_A_INT_STAT = 6'h31;
  localparam logic [5:0] VPT_A_INT_MASK = 6'h32;
  // NOV register slot: base + 4*i + field
  localparam logic [1:0] VPT_NOV_F_PICKUP = 2'h0;
  localparam logic [1:0] VPT_NOV_F_DELAY = 2'h1;
  localparam logic [1:0] VPT_NOV_F_CURVE = 2'h2;
  // ****************************************************************
  // Control fields and event bits
  // ****************************************************************
  localparam int VPT_C_PUV_EN = 0;
  localparam int VPT_C_PUV_INV = 1;
  localparam int VPT_C_PUV_PP = 2;
  localparam int VPT_C_DELTA = 3;
  localparam int VPT_C_NOV_EN = 4;
  localparam int VPT_C_AUX_EN = 7;
  localparam int VPT_C_AUX_INV = 8;
  localparam int VPT_E_PUV = 0;
  localparam int VPT_E_NOV = 1;
  localparam int VPT_E_AUX = 4;
  localparam logic [15:0] VPT_RST_ZERO = 16'h0000;
  localparam logic [1:0] VPT_CURVE_DEF = 2'h0;
endpackage : vpt_pkg

// ---- core/vpt_top.sv ----
// Voltage protection timing: phase and auxiliary undervoltage, three
// neutral overvoltage elements, register port and interrupt.
// Assumes fundamental magnitudes and phasors arrive synchronous to the
// core clock, already scaled to per-unit counts of the VT secondary.
`timescale 1ns/10ps

// ******************************************************************
// Timing element: one per protection function
// ******************************************************************
module vpt_elem
  import vpt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic en_i,
  input wire logic over_i,
  input wire logic inverse_i,
  input wire logic [VPT_DW-1:0] v_i,
  input wire logic [VPT_DW-1:0] pickup_i,
  input wire logic [VPT_DW-1:0] vmin_i,
  input wire logic [VPT_DW-1:0] mult_i,
  output logic op_o
);
  logic picked;
  logic [VPT_DW-1:0] inc;
  logic [VPT_ACCW-1:0] thresh;
  logic [VPT_ACCW:0] sum;
  logic [VPT_ACCW-1:0] acc_q;

  // Pickup test, with undervoltage blocking below the minimum voltage
  assign picked = en_i && (over_i ? (v_i > pickup_i)
                  : ((v_i < pickup_i) && (v_i >= vmin_i)));
  // Definite adds the pickup per tick; inverse adds the margin
  assign inc = !inverse_i ? pickup_i
             : (over_i ? (v_i - pickup_i) : (pickup_i - v_i));
  // Operate when delay*pickup is exceeded: T = D*Vp/(Vp-V) ticks
  assign thresh = mult_i * pickup_i;
  assign sum = {1'b0, acc_q} + {{(VPT_ACCW+1-VPT_DW){1'b0}}, inc};

  // Elapsed-time accumulator, cleared at once when not picked up
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      acc_q <= '0;
    end else if (ce_i) begin
      if (!picked) begin
        acc_q <= '0;
      end else if (tick_i) begin
        acc_q <= sum[VPT_ACCW] ? '1 : sum[VPT_ACCW-1:0];
      end
    end
  end

  // Operate flag: strictly past the threshold, so a partial first tick
  // never shortens the delay; a zero delay operates on the cycle after pickup
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      op_o <= 1'b0;
    end else if (ce_i) begin
      op_o <= picked
              && ((acc_q > thresh) || (mult_i == '0));
    end
  end

  property p_reset_instant;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (ce_i && !picked) |=> !op_o && (acc_q == '0);
  endproperty
  a_reset_instant: assert property (p_reset_instant)
    else $error("element did not reset at once");

  property p_zero_delay;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (ce_i && picked && mult_i == '0) |=> op_o;
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("zero delay did not operate next cycle");

  property p_block_min;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (ce_i && !over_i && v_i < vmin_i) |=> !op_o;
  endproperty
  a_block_min: assert property (p_block_min)
    else $error("undervoltage operated below minimum voltage");

  property p_min_time;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(op_o) |-> ($past(acc_q) > $past(thresh))
                      || ($past(mult_i) == '0);
  endproperty
  a_min_time: assert property (p_min_time)
    else $error("operated before threshold");

  property p_def_step;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (ce_i && picked && tick_i && !inverse_i && !sum[VPT_ACCW])
        |=> acc_q == $past(acc_q) + $past(pickup_i);
  endproperty
  a_def_step: assert property (p_def_step)
    else $error("definite step is not the pickup");

  property p_inv_step;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (ce_i && picked && tick_i && inverse_i && !over_i && !sum[VPT_ACCW])
        |=> acc_q == $past(acc_q) + ($past(pickup_i) - $past(v_i));
  endproperty
  a_inv_step: assert property (p_inv_step)
    else $error("inverse step is not the margin");

  property p_zero_volt;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (ce_i && picked && inverse_i && !over_i && v_i == '0)
        |-> inc == pickup_i;
  endproperty
  a_zero_volt: assert property (p_zero_volt)
    else $error("zero volts does not give plain delay");
endmodule : vpt_elem

// ******************************************************************
// Top: voltage selection, registers, interrupt
// ******************************************************************
module vpt_top
  import vpt_pkg::*;
#(
  parameter int TICK_CYCLES = VPT_TICK_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [VPT_AW-1:0] addr_i,
  input wire logic [VPT_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [VPT_DW-1:0] va_mag_i,
  input wire logic [VPT_DW-1:0] vb_mag_i,
  input wire logic [VPT_DW-1:0] vc_mag_i,
  input wire logic [VPT_DW-1:0] vab_mag_i,
  input wire logic [VPT_DW-1:0] vbc_mag_i,
  input wire logic [VPT_DW-1:0] vca_mag_i,
  input wire logic signed [VPT_DW-1:0] va_re_i,
  input wire logic signed [VPT_DW-1:0] va_im_i,
  input wire logic signed [VPT_DW-1:0] vb_re_i,
  input wire logic signed [VPT_DW-1:0] vb_im_i,
  input wire logic signed [VPT_DW-1:0] vc_re_i,
  input wire logic signed [VPT_DW-1:0] vc_im_i,
  input wire logic [VPT_DW-1:0] vaux_mag_i,
  output logic [VPT_DW-1:0] rdata_o,
  output logic puv_op_o,
  output logic [VPT_NOV_N-1:0] nov_op_o,
  output logic aux_op_o,
  output logic irq_o
);
  logic [VPT_DW-1:0] ctrl_q;
  logic [VPT_DW-1:0] puv_pickup_q, puv_min_q, puv_delay_q;
  logic [VPT_DW-1:0] auxiliary_low_voltage_threshold_q;
  logic [VPT_DW-1:0] aux_min_q;
  logic [VPT_DW-1:0] auxiliary_low_voltage_min_time_q;
  logic [VPT_DW-1:0] nov_pickup_q [VPT_NOV_N];
  logic [VPT_DW-1:0] neutral_high_voltage_fixed_delay_q [VPT_NOV_N];
  logic [1:0] neutral_high_voltage_curve_select_q [VPT_NOV_N];
  logic [VPT_DW-1:0] curve_mult_q [VPT_NOV_N];
  logic [VPT_EV_N-1:0] int_stat_q, int_mask_q, ops, ops_prev_q, rise;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [VPT_DW-1:0] puv_v, system_neutral_voltage;
  logic [VPT_DW+1:0] n_re, n_im;
  logic [VPT_DW+1:0] a_re, a_im, n_max, n_min;
  logic [VPT_DW+2:0] n_mag;
  logic wr_nov, wr_curve;
  logic [1:0] slot;

  function automatic logic [VPT_DW-1:0] min3(input logic [VPT_DW-1:0] a,
      input logic [VPT_DW-1:0] b, input logic [VPT_DW-1:0] c);
    logic [VPT_DW-1:0] m;
    m = (a < b) ? a : b;
    return (c < m) ? c : m;
  endfunction : min3

  // 10 ms timing tick shared by all elements
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= '0;
    end else if (ce_i) begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h1;
    end
  end

  // Phase voltage: phase-phase for delta, else as selected
  assign puv_v = (ctrl_q[VPT_C_DELTA] || ctrl_q[VPT_C_PUV_PP])
               ? min3(vab_mag_i, vbc_mag_i, vca_mag_i)
               : min3(va_mag_i, vb_mag_i, vc_mag_i);

  // Neutral voltage 3V0 as phasor sum; magnitude by max + min/2
  assign n_re = 18'(va_re_i) + 18'(vb_re_i) + 18'(vc_re_i);
  assign n_im = 18'(va_im_i) + 18'(vb_im_i) + 18'(vc_im_i);
  assign a_re = n_re[VPT_DW+1] ? -n_re : n_re;
  assign a_im = n_im[VPT_DW+1] ? -n_im : n_im;
  assign n_max = (a_re > a_im) ? a_re : a_im;
  assign n_min = (a_re > a_im) ? a_im : a_re;
  assign n_mag = {1'b0, n_max} + {2'b00, n_min[VPT_DW+1:1]};
  assign system_neutral_voltage = (|n_mag[VPT_DW+2:VPT_DW]) ? '1
                                : n_mag[VPT_DW-1:0];

  // Phase and auxiliary undervoltage elements
  vpt_elem u_puv (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .tick_i(tick), .en_i(ctrl_q[VPT_C_PUV_EN]), .over_i(1'b0),
    .inverse_i(ctrl_q[VPT_C_PUV_INV]), .v_i(puv_v),
    .pickup_i(puv_pickup_q), .vmin_i(puv_min_q),
    .mult_i(puv_delay_q), .op_o(ops[VPT_E_PUV]));
  vpt_elem u_aux (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .tick_i(tick), .en_i(ctrl_q[VPT_C_AUX_EN]), .over_i(1'b0),
    .inverse_i(ctrl_q[VPT_C_AUX_INV]), .v_i(vaux_mag_i),
    .pickup_i(auxiliary_low_voltage_threshold_q),
    .vmin_i(aux_min_q),
    .mult_i(auxiliary_low_voltage_min_time_q), .op_o(ops[VPT_E_AUX]));

  // Three neutral overvoltage elements; curve 0 is definite time
  genvar gi;
  for (gi = 0; gi < VPT_NOV_N; gi++) begin : g_nov
    logic defn;
    assign defn = (neutral_high_voltage_curve_select_q[gi] == VPT_CURVE_DEF);
    vpt_elem u_nov (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .tick_i(tick), .en_i(ctrl_q[VPT_C_NOV_EN + gi]), .over_i(1'b1),
      .inverse_i(!defn), .v_i(system_neutral_voltage),
      .pickup_i(nov_pickup_q[gi]), .vmin_i(VPT_RST_ZERO),
      .mult_i(defn ? neutral_high_voltage_fixed_delay_q[gi]
        : curve_mult_q[neutral_high_voltage_curve_select_q[gi] - 2'h1]),
      .op_o(ops[VPT_E_NOV + gi]));
  end

  // Register write decode
  assign slot = addr_i[3:2];
  assign wr_nov = wr_i && (addr_i[5:4] == VPT_A_NOV_BASE[5:4])
                && (slot < 2'(VPT_NOV_N));
  assign wr_curve = wr_i && (addr_i[5:2] == VPT_A_CURVE_BASE[5:2])
                  && (addr_i[1:0] < 2'(VPT_NOV_N));

  // Element settings
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= VPT_RST_ZERO;
      puv_pickup_q <= VPT_RST_ZERO;
      puv_min_q <= VPT_RST_ZERO;
      puv_delay_q <= VPT_RST_ZERO;
      auxiliary_low_voltage_threshold_q <= VPT_RST_ZERO;
      aux_min_q <= VPT_RST_ZERO;
      auxiliary_low_voltage_min_time_q <= VPT_RST_ZERO;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        VPT_A_CTRL: ctrl_q <= wdata_i;
        VPT_A_PUV_PICKUP: puv_pickup_q <= wdata_i;
        VPT_A_PUV_MIN: puv_min_q <= wdata_i;
        VPT_A_PUV_DELAY: puv_delay_q <= wdata_i;
        VPT_A_AUX_PICKUP: auxiliary_low_voltage_threshold_q <= wdata_i;
        VPT_A_AUX_MIN: aux_min_q <= wdata_i;
        VPT_A_AUX_DELAY: auxiliary_low_voltage_min_time_q <= wdata_i;
        default: ;
      endcase
    end
  end

  // Neutral element settings and curve multipliers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < VPT_NOV_N; i++) begin
        nov_pickup_q[i] <= VPT_RST_ZERO;
        neutral_high_voltage_fixed_delay_q[i] <= VPT_RST_ZERO;
        neutral_high_voltage_curve_select_q[i] <= VPT_CURVE_DEF;
        curve_mult_q[i] <= VPT_RST_ZERO;
      end
    end else if (ce_i) begin
      if (wr_nov) begin
        case (addr_i[1:0])
          VPT_NOV_F_PICKUP: nov_pickup_q[slot] <= wdata_i;
          VPT_NOV_F_DELAY:
            neutral_high_voltage_fixed_delay_q[slot] <= wdata_i;
          VPT_NOV_F_CURVE:
            neutral_high_voltage_curve_select_q[slot] <= wdata_i[1:0];
          default: ;
        endcase
      end
      if (wr_curve) begin
        curve_mult_q[addr_i[1:0]] <= wdata_i;
      end
    end
  end

  // Operate outputs and rising-edge events
  assign rise = ops & ~ops_prev_q;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ops_prev_q <= '0;
      puv_op_o <= 1'b0;
      nov_op_o <= '0;
      aux_op_o <= 1'b0;
    end else if (ce_i) begin
      ops_prev_q <= ops;
      puv_op_o <= ops[VPT_E_PUV];
      nov_op_o <= ops[VPT_E_NOV +: VPT_NOV_N];
      aux_op_o <= ops[VPT_E_AUX];
    end
  end

  // Sticky status, write one to clear; a new event wins over clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      int_stat_q <= '0;
      int_mask_q <= '0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_i && addr_i == VPT_A_INT_MASK) begin
        int_mask_q <= wdata_i[VPT_EV_N-1:0];
      end
      if (wr_i && addr_i == VPT_A_INT_STAT) begin
        int_stat_q <= (int_stat_q & ~wdata_i[VPT_EV_N-1:0]) | rise;
      end else begin
        int_stat_q <= int_stat_q | rise;
      end
      irq_o <= |(int_stat_q & int_mask_q);
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= VPT_RST_ZERO;
    end else if (ce_i) begin
      rdata_o <= VPT_RST_ZERO;
      if (rd_i) begin
        case (addr_i)
          VPT_A_CTRL: rdata_o <= ctrl_q;
          VPT_A_PUV_PICKUP: rdata_o <= puv_pickup_q;
          VPT_A_PUV_MIN: rdata_o <= puv_min_q;
          VPT_A_PUV_DELAY: rdata_o <= puv_delay_q;
          VPT_A_AUX_PICKUP: rdata_o <= auxiliary_low_voltage_threshold_q;
          VPT_A_AUX_MIN: rdata_o <= aux_min_q;
          VPT_A_AUX_DELAY: rdata_o <= auxiliary_low_voltage_min_time_q;
          VPT_A_STATUS: rdata_o <= 16'(ops);
          VPT_A_INT_STAT: rdata_o <= 16'(int_stat_q);
          VPT_A_INT_MASK: rdata_o <= 16'(int_mask_q);
          default: begin
            if (addr_i[5:4] == VPT_A_NOV_BASE[5:4]
                && slot < 2'(VPT_NOV_N)) begin
              case (addr_i[1:0])
                VPT_NOV_F_PICKUP: rdata_o <= nov_pickup_q[slot];
                VPT_NOV_F_DELAY:
                  rdata_o <= neutral_high_voltage_fixed_delay_q[slot];
                VPT_NOV_F_CURVE:
                  rdata_o <= 16'(neutral_high_voltage_curve_select_q[slot]);
                default: rdata_o <= VPT_RST_ZERO;
              endcase
            end else if (addr_i[5:2] == VPT_A_CURVE_BASE[5:2]
                         && addr_i[1:0] < 2'(VPT_NOV_N)) begin
              rdata_o <= curve_mult_q[addr_i[1:0]];
            end
          end
        endcase
      end
    end
  end

  property p_delta_pp;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ctrl_q[VPT_C_DELTA] |-> puv_v == min3(vab_mag_i, vbc_mag_i, vca_mag_i);
  endproperty
  a_delta_pp: assert property (p_delta_pp)
    else $error("delta connection did not use phase-phase voltage");

  property p_irq;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (ce_i && |(int_stat_q & int_mask_q)) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised for unmasked status");

  property p_event_kept;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (ce_i && |rise) |=> (int_stat_q & $past(rise)) == $past(rise);
  endproperty
  a_event_kept: assert property (p_event_kept)
    else $error("event lost against clear");
endmodule : vpt_top

// ---- dv/vpt_vt_model.sv ----
// Voltage transformer front end feeding the protection timing block.
// Assumes the bench sets per-unit levels; outputs follow combinationally.
`timescale 1ns/10ps

// ****************************************************************
// Measurement model
// ****************************************************************
module vpt_vt_model
  import vpt_pkg::*;
(
  input wire logic [VPT_DW-1:0] pg_i,
  input wire logic [VPT_DW-1:0] pp_i,
  input wire logic [VPT_DW-1:0] vn_i,
  input wire logic [VPT_DW-1:0] vx_i,
  output logic [VPT_DW-1:0] va_mag_o,
  output logic [VPT_DW-1:0] vb_mag_o,
  output logic [VPT_DW-1:0] vc_mag_o,
  output logic [VPT_DW-1:0] vab_mag_o,
  output logic [VPT_DW-1:0] vbc_mag_o,
  output logic [VPT_DW-1:0] vca_mag_o,
  output logic signed [VPT_DW-1:0] va_re_o,
  output logic signed [VPT_DW-1:0] va_im_o,
  output logic signed [VPT_DW-1:0] vb_re_o,
  output logic signed [VPT_DW-1:0] vb_im_o,
  output logic signed [VPT_DW-1:0] vc_re_o,
  output logic signed [VPT_DW-1:0] vc_im_o,
  output logic [VPT_DW-1:0] vaux_mag_o
);
  // Balanced magnitudes per group
  assign {va_mag_o, vb_mag_o, vc_mag_o} = {3{pg_i}};
  assign {vab_mag_o, vbc_mag_o, vca_mag_o} = {3{pp_i}};
  // Wye phase VTs: residual appears on phase a only
  assign va_re_o = vn_i;
  assign {va_im_o, vb_re_o, vb_im_o, vc_re_o, vc_im_o} = '0;
  assign vaux_mag_o = vx_i;
endmodule : vpt_vt_model

// ---- dv/tb.sv ----
// Self-checking bench for the voltage protection timing block.
// Assumes a shortened tick and the measurement model on the inputs.
`timescale 1ns/10ps
module tb;
  import vpt_pkg::*;
  localparam int TK = 8;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [VPT_AW-1:0] addr_i = '0;
  logic [VPT_DW-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [VPT_DW-1:0] pg = 16'h2000, pp = 16'h2000, vn = '0, vx = 16'h2000;
  logic [VPT_DW-1:0] am, bm, cm, abm, bcm, cam, xm, rdata;
  logic signed [VPT_DW-1:0] ar, ai, br, bi, cr, ci;
  logic puv, aux, irq;
  logic [VPT_NOV_N-1:0] nov;
  wire [4:0] ops = {aux, nov, puv};
  int n_mismatch = 0;
  int tests_run = 0;
  int seed;
  int d;
  logic [VPT_DW-1:0] p;

  // Clock at 100 ns
  always #50 core_clk_i = ~core_clk_i;

  vpt_vt_model vt (.pg_i(pg), .pp_i(pp), .vn_i(vn), .vx_i(vx),
    .va_mag_o(am), .vb_mag_o(bm), .vc_mag_o(cm), .vab_mag_o(abm),
    .vbc_mag_o(bcm), .vca_mag_o(cam), .va_re_o(ar), .va_im_o(ai),
    .vb_re_o(br), .vb_im_o(bi), .vc_re_o(cr), .vc_im_o(ci),
    .vaux_mag_o(xm));

  vpt_top #(.TICK_CYCLES(TK)) uut (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .va_mag_i(am), .vb_mag_i(bm),
    .vc_mag_i(cm), .vab_mag_i(abm), .vbc_mag_i(bcm), .vca_mag_i(cam),
    .va_re_i(ar), .va_im_i(ai), .vb_re_i(br), .vb_im_i(bi),
    .vc_re_i(cr), .vc_im_i(ci), .vaux_mag_i(xm), .rdata_o(rdata),
    .puv_op_o(puv), .nov_op_o(nov), .aux_op_o(aux), .irq_o(irq));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic wrap_up();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : settle

  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [15:0] e, string nm);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask : rd

  // Operate must land between n and n+1 ticks after pickup
  task automatic timed(input int idx, input int n, input string nm);
    int c;
    c = 0;
    while (ops[idx] !== 1'b1 && c < (n + 2) * TK + 8) begin
      @(posedge core_clk_i);
      #1;
      c++;
    end
    tests_run++;
    if (c < n * TK || c > (n + 1) * TK + 4) begin
      n_mismatch++;
      $display("mismatch %s exp %0d..%0d got %0d", nm, n * TK,
        (n + 1) * TK + 4, c);
    end
  endtask : timed

  function automatic logic [5:0] nova(input int i, input logic [1:0] f);
    return VPT_A_NOV_BASE + 6'(4 * i) + {4'h0, f};
  endfunction : nova

  // Watchdog
  initial begin
    #2000000;
    n_mismatch++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'h86cec8cf;
    d = 2 + ($random(seed) & 3);
    p = 16'h0800 + 16'($random(seed) & 16'h03fe);
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(VPT_A_CTRL, 16'h0000, "ctrl reset");
    rd(VPT_A_INT_STAT, 16'h0000, "int_stat reset");
    rd(6'h3f, 16'h0000, "unmapped");
    // Phase element, zero delay, prompt operate
    wr(VPT_A_PUV_PICKUP, p);
    wr(VPT_A_CTRL, 16'h0001);
    pg <= p - 16'h0001;
    settle(3);
    chk("puv zero delay", 16'h1, 16'(puv));
    pg <= p;
    settle(4);
    chk("puv dropout", 16'h0, 16'(puv));
    // Definite time at the pickup boundary
    wr(VPT_A_PUV_DELAY, 16'(d));
    settle((d + 2) * TK);
    chk("puv at pickup", 16'h0, 16'(puv));
    pg <= p - 16'h0001;
    timed(0, d, "puv definite");
    // Minimum voltage blocking
    wr(VPT_A_PUV_MIN, 16'h0200);
    pg <= 16'h0100;
    settle((d + 2) * TK);
    chk("puv blocked", 16'h0, 16'(puv));
    pg <= 16'h0200;
    timed(0, d, "puv at min");
    // Inverse time, dead source then half pickup
    wr(VPT_A_PUV_MIN, 16'h0000);
    wr(VPT_A_CTRL, 16'h0003);
    pg <= 16'h2000;
    settle(4);
    pg <= 16'h0000;
    timed(0, d, "puv inverse zero");
    pg <= 16'h2000;
    settle(4);
    pg <= p >> 1;
    timed(0, 2 * d, "puv inverse half");
    // Voltage selection: delta forces phase-phase
    pg <= 16'h2000;
    wr(VPT_A_PUV_DELAY, 16'h0000);
    wr(VPT_A_CTRL, 16'h0009);
    pg <= 16'h0100;
    settle(6);
    chk("delta ignores pg", 16'h0, 16'(puv));
    pp <= 16'h0100;
    settle(4);
    chk("delta uses pp", 16'h1, 16'(puv));
    rd(VPT_A_STATUS, 16'h0001, "status");
    settle(1);
    chk("rdata one cycle", 16'h0, rdata);
    // Interrupt raise, mask, clear
    rd(VPT_A_INT_STAT, 16'h0001, "int_stat set");
    chk("irq masked", 16'h0, 16'(irq));
    wr(VPT_A_INT_MASK, 16'h0001);
    settle(3);
    chk("irq on", 16'h1, 16'(irq));
    wr(VPT_A_INT_STAT, 16'h0001);
    settle(3);
    chk("irq cleared", 16'h0, 16'(irq));
    wr(VPT_A_CTRL, 16'h0001);
    pg <= 16'h2000;
    settle(4);
    chk("wye pg mode", 16'h0, 16'(puv));
    wr(VPT_A_CTRL, 16'h0005);
    settle(4);
    chk("wye pp mode", 16'h1, 16'(puv));
    // Auxiliary element
    pp <= 16'h2000;
    wr(VPT_A_AUX_PICKUP, p);
    wr(VPT_A_AUX_MIN, 16'h0100);
    wr(VPT_A_AUX_DELAY, 16'(d));
    wr(VPT_A_CTRL, 16'h0080);
    vx <= p - 16'h0001;
    timed(4, d, "aux definite");
    vx <= p;
    settle(4);
    chk("aux reset", 16'h0, 16'(aux));
    vx <= 16'h0080;
    settle((d + 2) * TK);
    chk("aux blocked", 16'h0, 16'(aux));
    wr(VPT_A_CTRL, 16'h0180);
    vx <= p >> 1;
    timed(4, 2 * d, "aux inverse");
    vx <= 16'h2000;
    // Three neutral instances, one at a time
    for (int i = 0; i < VPT_NOV_N; i++) begin
      wr(nova(i, VPT_NOV_F_PICKUP), 16'h0400);
      wr(nova(i, VPT_NOV_F_DELAY), 16'(d + i));
      wr(VPT_A_CTRL, 16'(1 << (VPT_C_NOV_EN + i)));
      vn <= 16'h0401;
      timed(1 + i, d + i, "nov definite");
      chk("nov only one", 16'(1 << i), 16'(nov));
      vn <= 16'h0000;
      settle(4);
    end
    // Curve A ignores the fixed delay
    wr(VPT_A_CURVE_BASE, 16'h0003);
    wr(nova(0, VPT_NOV_F_DELAY), 16'd40);
    wr(nova(0, VPT_NOV_F_CURVE), 16'h0001);
    wr(VPT_A_CTRL, 16'h0010);
    vn <= 16'h0800;
    timed(1, 3, "nov curve");
    // Clock enable low freezes timing; a mid-run reset clears all
    vn <= 16'h0000;
    settle(4);
    ce_i <= 1'b0;
    vn <= 16'h0800;
    settle(6 * TK);
    chk("ce frozen", 16'h0, 16'(nov));
    ce_i <= 1'b1;
    timed(1, 3, "nov after ce");
    rst_n_i <= 1'b0;
    settle(2);
    rst_n_i <= 1'b1;
    chk("reset ops", 16'h0, 16'(ops));
    rd(VPT_A_INT_STAT, 16'h0000, "int_stat after reset");
    rd(nova(0, VPT_NOV_F_CURVE), 16'h0000, "curve after reset");
    wrap_up();
  end
endmodule : tb
